// ---- design/amr_read_channel.sv ----
`timescale 1ns/1ps
`include "amr_regs.svh"
module amr_read_channel #(
  parameter bit MEM_SLAVE = 1'b1,  // 1 memory slave, 0 peripheral slave
  parameter bit ID_EN     = 1'b1,
  parameter int ID_W      = 4,
  parameter int DW        = 32
) (
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  input  wire logic [31:0]     s_axi_araddr,
  input  wire logic [ID_W-1:0] s_axi_arid,
  input  wire logic [7:0]      s_axi_arlen,
  input  wire logic [2:0]      s_axi_arsize,
  input  wire logic [1:0]      s_axi_arburst,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [DW-1:0]        s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic [ID_W-1:0]      s_axi_rid,
  output logic                 s_axi_rlast,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [`AMR_MEM_AW-1:0] mem_wr_addr,
  input  wire logic [DW-1:0]          mem_wr_data,
  input  wire logic                   mem_wr_en
);
  localparam int LB = $clog2(DW / 8);
  localparam bit HAS_ID   = MEM_SLAVE && ID_EN;
  localparam bit BURSTING = MEM_SLAVE;

  initial begin
    if (ID_W < 1 || ID_W > 16) $error("id width out of range");
    if (MEM_SLAVE && !(DW == 32 || DW == 64)) $error("bad memory width");
    if (!MEM_SLAVE && !(DW == 8 || DW == 16 || DW == 32 || DW == 64))
      $error("bad peripheral width");
  end

  ////////////////////////////////////////////////////////////////////////////
  amr_pkg::amr_state_t state_ff, nxt_state;
  logic [`AMR_MEM_AW-1:0] addr_ff, nxt_addr;
  logic [`AMR_MEM_AW-1:0] wrap_mask_ff, nxt_wrap_mask;
  logic [7:0]      left_ff, nxt_left;
  logic [1:0]      burst_ff, nxt_burst;
  logic [ID_W-1:0] id_ff, nxt_id;
  logic [DW-1:0]   data_ff, nxt_data;
  logic [DW-1:0]   mem_q;
  logic            ar_fire, r_fire;
  logic [`AMR_MEM_AW-1:0] step_addr;

  // memory is word addressed; byte offset bits dropped
  // the read address is the next address, so the registered read lands
  // in the fetch cycle instead of trailing one address behind
  amr_mem #(.DW(DW)) u_mem (
    .sys_clk    (sys_clk),
    .wr_addr    (mem_wr_addr),
    .wr_data    (mem_wr_data),
    .wr_en      (mem_wr_en),
    .rd_addr    (nxt_addr),
    .rd_data_ff (mem_q)
  );

  // arsize is taken but unused: every beat is a full-width word
  // one transaction at a time: simple, no read reordering
  assign s_axi_arready = (state_ff == amr_pkg::AMR_IDLE);
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign r_fire  = s_axi_rvalid && s_axi_rready;
  assign s_axi_rvalid = (state_ff == amr_pkg::AMR_SEND);
  assign s_axi_rdata  = data_ff;
  assign s_axi_rresp  = `AMR_RESP_OKAY;
  assign s_axi_rid    = HAS_ID ? id_ff : '0;
  assign s_axi_rlast  = s_axi_rvalid && (left_ff == `AMR_LEN_ZERO);

  // next beat address; wrap keeps upper bits of the aligned window
  // wrap assumes a power-of-two beat count, as the master must send
  always_comb begin
    step_addr = addr_ff + `AMR_ADDR_ONE;
    if (burst_ff == `AMR_BURST_FIXED) begin
      step_addr = addr_ff;
    end else if (burst_ff == `AMR_BURST_WRAP) begin
      step_addr = (addr_ff & ~wrap_mask_ff) | (step_addr & wrap_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transaction sequencer
  always_comb begin
    nxt_state     = state_ff;
    nxt_addr      = addr_ff;
    nxt_wrap_mask = wrap_mask_ff;
    nxt_left      = left_ff;
    nxt_burst     = burst_ff;
    nxt_id        = id_ff;
    nxt_data      = data_ff;
    case (state_ff)
      amr_pkg::AMR_IDLE: begin
        if (ar_fire) begin
          // start address is taken, length and burst only in a memory slave, id only with HAS_ID; later beat addresses are derived
          nxt_addr      = s_axi_araddr[LB +: `AMR_MEM_AW];
          nxt_left      = BURSTING ? s_axi_arlen : `AMR_LEN_ZERO;
          nxt_burst     = BURSTING ? s_axi_arburst : `AMR_BURST_INCR;
          nxt_wrap_mask = (`AMR_MEM_AW)'(s_axi_arlen);
          nxt_id        = HAS_ID ? s_axi_arid : '0;
          nxt_state     = amr_pkg::AMR_FETCH;
        end
      end
      amr_pkg::AMR_FETCH: begin
        nxt_data  = mem_q;  // registered memory output now valid
        nxt_state = amr_pkg::AMR_SEND;
      end
      amr_pkg::AMR_SEND: begin
        // data, id and valid hold until the beat is taken
        if (r_fire) begin
          if (left_ff == `AMR_LEN_ZERO) begin
            nxt_state = amr_pkg::AMR_IDLE;
          end else begin
            nxt_left  = left_ff - `AMR_BEAT_ONE;
            nxt_addr  = step_addr;
            nxt_state = amr_pkg::AMR_FETCH;
          end
        end
      end
      default: nxt_state = amr_pkg::AMR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_ff     <= amr_pkg::AMR_IDLE;
      addr_ff      <= '0;
      wrap_mask_ff <= '0;
      left_ff      <= `AMR_LEN_ZERO;
      burst_ff     <= `AMR_BURST_INCR;
      id_ff        <= '0;
      data_ff      <= DW'(`AMR_MEM_INIT);
    end else begin
      state_ff     <= nxt_state;
      addr_ff      <= nxt_addr;
      wrap_mask_ff <= nxt_wrap_mask;
      left_ff      <= nxt_left;
      burst_ff     <= nxt_burst;
      id_ff        <= nxt_id;
      data_ff      <= nxt_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_rvalid_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rid))
    else $error("read beat changed before acceptance");
  chk_resp_okay: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_axi_rvalid |-> s_axi_rresp == `AMR_RESP_OKAY)
    else $error("response not okay");
  chk_ready_busy: assert property (@(posedge sys_clk) disable iff (!resetn)
    ar_fire |=> !s_axi_arready ##1 s_axi_rvalid)
    else $error("address taken while busy or data late");
  chk_rid_match: assert property (@(posedge sys_clk) disable iff (!resetn)
    ar_fire && HAS_ID |=> ##1 s_axi_rid == $past(s_axi_arid, 2))
    else $error("read id mismatch");
  chk_beat_done: assert property (@(posedge sys_clk) disable iff (!resetn)
    r_fire && !s_axi_rlast |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("next beat not fetched in two cycles");
  chk_last_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    r_fire && s_axi_rlast |=> s_axi_arready && !s_axi_rvalid)
    else $error("no return to idle after last beat");
  chk_addr_start: assert property (@(posedge sys_clk) disable iff (!resetn)
    ar_fire |=> addr_ff == $past(s_axi_araddr[LB +: `AMR_MEM_AW]))
    else $error("start address not captured");
  chk_valid_src: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(s_axi_rvalid) |-> $past(state_ff) == amr_pkg::AMR_FETCH)
    else $error("valid raised without fetched data");

  // the beat walk follows the burst type captured with the start address
  chk_incr_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    r_fire && !s_axi_rlast && burst_ff == `AMR_BURST_INCR
      |=> addr_ff == $past(addr_ff) + `AMR_ADDR_ONE)
    else $error("incrementing burst skipped a word");
  // a fixed burst rereads one word for every beat
  chk_fixed_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    r_fire && burst_ff == `AMR_BURST_FIXED |=> addr_ff == $past(addr_ff))
    else $error("fixed burst moved its address");
  // a wrapping burst never leaves its aligned window
  chk_wrap_window: assert property (@(posedge sys_clk) disable iff (!resetn)
    r_fire && !s_axi_rlast && burst_ff == `AMR_BURST_WRAP
      |=> (addr_ff & ~wrap_mask_ff) == ($past(addr_ff) & ~wrap_mask_ff))
    else $error("wrapping burst left its window");
  // in a memory slave the beat count comes from the length given with the address
  chk_len_taken: assert property (@(posedge sys_clk) disable iff (!resetn)
    ar_fire && BURSTING |=> left_ff == $past(s_axi_arlen))
    else $error("burst length not captured");
  // each accepted beat that is not the last counts one down
  chk_left_count: assert property (@(posedge sys_clk) disable iff (!resetn)
    r_fire && !s_axi_rlast |=> left_ff == $past(left_ff) - `AMR_BEAT_ONE)
    else $error("beat count did not step");
  // no new address is taken until the last beat has gone
  chk_busy_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !s_axi_arready && !(r_fire && s_axi_rlast) |=> !s_axi_arready)
    else $error("address ready rose inside a burst");
  // fresh data on every rising valid comes straight from the memory register
  chk_data_fetch: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(s_axi_rvalid) |-> s_axi_rdata == $past(mem_q))
    else $error("beat data not taken from memory");
  // synchronous reset leaves the channel idle one edge later
  chk_reset_idle: assert property (@(posedge sys_clk)
    !resetn |=> s_axi_arready && !s_axi_rvalid && !s_axi_rlast)
    else $error("channel not idle after reset");
endmodule // amr_read_channel

// ---- design/amr_regs.svh ----
`ifndef AMR_REGS_SVH
`define AMR_REGS_SVH
// read response code: always okay
`define AMR_RESP_OKAY     2'h0
// burst types
`define AMR_BURST_FIXED   2'h0
`define AMR_BURST_INCR    2'h1
`define AMR_BURST_WRAP    2'h2
// memory geometry
`define AMR_MEM_AW        8
`define AMR_MEM_DEPTH     256
`define AMR_MEM_INIT      64'h0
`define AMR_LEN_ZERO      8'h00
`define AMR_ADDR_ONE      8'h01
`define AMR_BEAT_ONE      8'h01
`endif

// ---- design/amr_pkg.sv ----
package amr_pkg;
  typedef enum logic [1:0] {AMR_IDLE, AMR_FETCH, AMR_SEND} amr_state_t;
endpackage

// ---- design/amr_mem.sv ----
`timescale 1ns/1ps
`include "amr_regs.svh"
module amr_mem #(
  parameter int DW = 32
) (
  input  wire logic                   sys_clk,
  input  wire logic [`AMR_MEM_AW-1:0] wr_addr,
  input  wire logic [DW-1:0]          wr_data,
  input  wire logic                   wr_en,
  input  wire logic [`AMR_MEM_AW-1:0] rd_addr,
  output logic      [DW-1:0]          rd_data_ff
);
  logic [DW-1:0] mem [`AMR_MEM_DEPTH];

  // registered read port, one cycle latency
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule // amr_mem

// ---- tb/amr_master.sv ----
`timescale 1ns/1ps
// master side: holds a request until it is taken and can stall read data
module amr_master (
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [31:0] addr,
  input  wire logic [3:0]  id,
  input  wire logic [7:0]  len,
  input  wire logic [1:0]  burst,
  input  wire logic        arready,
  output logic             arvalid = 1'b0,
  output logic [31:0]      araddr  = 32'h0,
  output logic [3:0]       arid    = 4'h0,
  output logic [7:0]       arlen   = 8'h00,
  output logic [1:0]       arburst = 2'h1,
  output logic             rready  = 1'b1
);
  logic took = 1'b0;
  // an address counts as taken only on an edge with valid and ready high
  always @(posedge sys_clk) took <= arvalid && arready;
  // released address and id lines show the inverse so a stale value never passes
  always @(negedge sys_clk) begin
    rready <= slow ? ~rready : 1'b1;
    if (arvalid && took) begin
      arvalid <= 1'b0;
      araddr  <= ~araddr;
      arid    <= ~arid;
    end else if (go && !arvalid) begin
      arvalid <= 1'b1;
      araddr  <= addr;
      arid    <= id;
      arlen   <= len;
      arburst <= burst;
    end
  end
endmodule // amr_master

// ---- tb/amr_read_channel_bench.sv ----
`timescale 1ns/1ps
`include "amr_regs.svh"
module amr_read_channel_bench;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        go = 1'b0, slow = 1'b0, we = 1'b0;
  logic [31:0] a = 32'h0, wd = 32'h0, rdata;
  logic [31:0] araddr;
  logic [7:0]  len = 8'h00, wa = 8'h00, arlen;
  logic [3:0]  id = 4'h0, arid, rid;
  logic [1:0]  bt = 2'h1, arburst, rresp;
  logic        arvalid, arready, rvalid, rready, rlast;
  int          mismatches = 0, n_tests = 0;
  always #10 sys_clk = ~sys_clk;
  amr_master u_master (.sys_clk(sys_clk), .go(go), .slow(slow), .addr(a), .id(id),
    .len(len), .burst(bt), .arready(arready), .arvalid(arvalid), .araddr(araddr),
    .arid(arid), .arlen(arlen), .arburst(arburst), .rready(rready));
  amr_read_channel #(.MEM_SLAVE(1'b1), .ID_EN(1'b1), .ID_W(4), .DW(32)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .s_axi_araddr(araddr), .s_axi_arid(arid),
    .s_axi_arlen(arlen), .s_axi_arsize(3'h2), .s_axi_arburst(arburst),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rid(rid), .s_axi_rlast(rlast), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mem_wr_addr(wa), .mem_wr_data(wd), .mem_wr_en(we));
  ////////////////////////////////////////////////////////////////////////////////
  // word pattern differs in three of its four bytes so a wrong index shows up
  function automatic logic [31:0] pat(input logic [7:0] i);
    return {i, ~i, 8'h5A, i};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one burst: issue it, then judge each beat a quarter cycle before its edge
  task automatic rd(input logic [31:0] sa, input logic [3:0] si, input logic [7:0] sl,
                    input logic [1:0] sb, input logic ss);
    int n, k;
    logic [7:0] w, x;
    logic [31:0] hd;
    logic hv;
    @(negedge sys_clk);
    a <= sa;
    id <= si;
    len <= sl;
    bt <= sb;
    slow <= ss;
    go <= 1'b1;
    @(negedge sys_clk);
    go <= 1'b0;
    w = sa[9:2];
    n = 0;
    k = 0;
    hv = 1'b0;
    hd = 32'h0;
    while (n <= sl && k < 100) begin
      @(negedge sys_clk);
      #5;
      k++;
      if (hv) chk(rdata, hd);
      if (hv) chk(rvalid, 1'b1);
      hv = rvalid && !rready;
      hd = rdata;
      if (rvalid && rready) begin
        x = (sb == `AMR_BURST_FIXED) ? w : (sb == `AMR_BURST_WRAP) ?
            ((w & ~sl) | ((w + 8'(n)) & sl)) : w + 8'(n);
        chk(rdata, pat(x));
        chk(32'(rid), 32'(si));
        chk(rresp, `AMR_RESP_OKAY);
        chk(rlast, n == sl);
        chk(arready, 1'b0);
        n++;
      end
    end
    if (k == 100) chk(n, sl + 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // cut a hang short well past the expected few hundred cycles
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  // reset, backdoor load, then incrementing bursts without stalls, a fixed burst with one stall, and a wrapping burst in slow mode that never stalls
  initial begin
    repeat (5) @(negedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    chk(arready, 1'b1);
    chk(rvalid, 1'b0);
    for (int i = 0; i < `AMR_MEM_DEPTH; i++) begin
      wa <= 8'(i);
      wd <= pat(8'(i));
      we <= 1'b1;
      @(negedge sys_clk);
    end
    we <= 1'b0;
    rd(32'h10, 4'h3, 8'h03, `AMR_BURST_INCR, 1'b0);
    rd(32'h20, 4'hC, 8'h02, `AMR_BURST_FIXED, 1'b1);
    rd(32'h3C, 4'h5, 8'h03, `AMR_BURST_WRAP, 1'b1);
    rd(32'h3FC, 4'hF, 8'h00, `AMR_BURST_INCR, 1'b0);
    // reset in mid-run: the last beat's id and data must clear, memory stays
    @(negedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(negedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    chk(arready, 1'b1);
    chk(rvalid, 1'b0);
    chk(rlast, 1'b0);
    chk(rdata, 32'(`AMR_MEM_INIT));
    chk(32'(rid), 32'h0);
    rd(32'h0, 4'h0, 8'h00, `AMR_BURST_INCR, 1'b0);
    @(negedge sys_clk);
    chk(arready, 1'b1);
    conclude();
  end
endmodule // amr_read_channel_bench
